// >>> logic/wdog_pkg.sv
package wdog_pkg;
   // Register byte addresses on the Avalon-MM slave port.
   localparam logic [15:0] CTRL_ADDR = 16'h1100;
   localparam logic [15:0] SRV_ADDR = 16'h1104;
   localparam int ADDR_W = 16;

   // Control register field positions.
   localparam int CTRL_WIN_BIT = 0;
   localparam int CTRL_RANGE_BIT = 1;
   localparam int CTRL_TO_LSB = 2;
   localparam int CTRL_STP_BIT = 4;
   localparam int CTRL_DBG_BIT = 5;
   localparam int CTRL_CLK_LSB = 6;
   localparam logic [7:0] CTRL_RESET = 8'h0C;

   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   localparam logic [1:0] TO_OFF = 2'h0;
   localparam logic [1:0] TO_SEL1 = 2'h1;
   localparam logic [1:0] TO_SEL2 = 2'h2;
   localparam logic [1:0] TO_SEL3 = 2'h3;
   localparam logic [1:0] CLK_LPO = 2'h0;
   localparam logic [1:0] CLK_IRC = 2'h1;
   localparam logic [1:0] CLK_OSC = 2'h2;
   localparam logic [1:0] CLK_BUS = 2'h3;

   // Timeout lengths as powers of two of counter clock cycles.
   localparam logic [4:0] EXP_S1 = 5'h05;
   localparam logic [4:0] EXP_S2 = 5'h08;
   localparam logic [4:0] EXP_S3 = 5'h0A;
   localparam logic [4:0] EXP_L1 = 5'h0D;
   localparam logic [4:0] EXP_L2 = 5'h10;
   localparam logic [4:0] EXP_L3 = 5'h12;
   localparam int CNT_W = 18;

   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [0:0] {
      KEY_IDLE = 1'b0,
      KEY_ARMED = 1'b1
   } key_state_e;
endpackage

// >>> logic/windowed_watchdog.sv
`timescale 1ns/100ps
// Function
// - Timeout select 00 disables the watchdog; otherwise it and range set the period.
// - Select 01 times out after 32 short or 8192 long counter cycles.
// - Select 10 times out after 256 short or 65536 long counter cycles.
// - Select 11 times out after 1024 short or 262144 long counter cycles.
// - Range bit 0 picks the short range, 1 the long range.
// - Only the first control write after reset is taken; later ones are ignored.
// - Windowed mode works for every clock source, only with the long range.
// - Window opens at three quarters of the timeout; earlier service resets.
// - The service register is write-only; reads answer with a transfer error.
// - Any other value written to the service register resets at once.
// - Service writes leave the control register alone; they drive key detection, counter restart and reset request.
// - A completed key sequence clears the counter and restarts the timeout.
// - Reaching the timeout without a completed service resets the system.
// - After reset the watchdog runs from the 1 kHz clock, 1024 cycles.
// - Clock select 00 is 1 kHz, 01 the RC clock, 10 the crystal.
// - Clock select 11 counts on the bus clock.
// - Debug enable 0 holds the counter cleared in debug; 1 keeps running.
// - Stop enable 0 holds the counter cleared in stop; 1 keeps running, except on the bus clock, where it holds its value.
module windowed_watchdog
   import wdog_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [wdog_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic [1:0] avs_response_o,
   output logic avs_waitrequest_o,
   input wire logic lpo_clk_i,
   input wire logic irc_clk_i,
   input wire logic osc_clk_i,
   input wire logic debug_mode_i,
   input wire logic stop_mode_i,
   output logic watchdog_reset_o
);
   import wdog_pkg::*;

   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] resp_ff, nxt_resp;
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic locked_ff, nxt_locked;
   key_state_e key_ff, nxt_key;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic rst_req_ff, nxt_rst_req;
   logic [2:0] meta_ff, sync_ff, last_ff;
   logic [2:0] src_rise;
   logic [2:0] src_pin;

   logic req, accept, wr_ctrl, wr_srv, ctrl_first;
   logic [1:0] to_sel, clk_sel;
   logic enabled, long_rng, win_mode, hold_clear, tick;
   logic [4:0] exp_sel;
   logic [CNT_W-1:0] limit, win_open;
   logic key_bad, service_ok, premature, timeout;

   assign src_pin = {osc_clk_i, irc_clk_i, lpo_clk_i};

   // Counter clock pins are sampled twice before the edge detector sees them.
   generate
      for (genvar i = 0; i < 3; i++) begin : g_src_sync
         always_ff @(posedge mclk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               meta_ff[i] <= 1'b0;
               sync_ff[i] <= 1'b0;
               last_ff[i] <= 1'b0;
            end else begin
               meta_ff[i] <= src_pin[i];
               sync_ff[i] <= meta_ff[i];
               last_ff[i] <= sync_ff[i];
            end
         end
         assign src_rise[i] = sync_ff[i] & ~last_ff[i];
      end
   endgenerate

   // Every access waits exactly one cycle, then completes.
   assign req = avs_read_i | avs_write_i;
   assign accept = req & ack_ff;
   assign avs_waitrequest_o = req & ~ack_ff;
   assign avs_readdata_o = rdata_ff;
   assign avs_response_o = resp_ff;
   assign watchdog_reset_o = rst_req_ff;

   assign wr_ctrl = accept & avs_write_i & (avs_address_i == CTRL_ADDR) & avs_byteenable_i[0];
   assign wr_srv = accept & avs_write_i & (avs_address_i == SRV_ADDR) & avs_byteenable_i[0];
   assign ctrl_first = wr_ctrl & ~locked_ff;

   always_comb begin
      nxt_ack = req & ~ack_ff;
      nxt_rdata = rdata_ff;
      nxt_resp = resp_ff;
      if (avs_read_i & ~ack_ff) begin
         nxt_rdata = 32'h0000_0000;
         nxt_resp = RESP_DECERR;
         if (avs_address_i == CTRL_ADDR) begin
            nxt_rdata = {24'h00_0000, ctrl_ff};
            nxt_resp = RESP_OK;
         end else if (avs_address_i == SRV_ADDR) begin
            nxt_resp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         resp_ff <= RESP_OK;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         resp_ff <= nxt_resp;
      end
   end

   // Control register: the first write after reset locks every field.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_locked = locked_ff;
      if (ctrl_first) begin
         nxt_ctrl = avs_writedata_i[7:0];
         nxt_locked = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_ff <= CTRL_RESET;
         locked_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         locked_ff <= nxt_locked;
      end
   end

   assign to_sel = ctrl_ff[CTRL_TO_LSB +: 2];
   assign clk_sel = ctrl_ff[CTRL_CLK_LSB +: 2];
   assign long_rng = ctrl_ff[CTRL_RANGE_BIT];
   assign enabled = (to_sel != TO_OFF);
   assign win_mode = ctrl_ff[CTRL_WIN_BIT] & long_rng;
   assign hold_clear = (debug_mode_i & ~ctrl_ff[CTRL_DBG_BIT])
                     | (stop_mode_i & ~ctrl_ff[CTRL_STP_BIT]);

   always_comb begin
      unique case (to_sel)
         TO_OFF: exp_sel = EXP_S1;
         TO_SEL1: exp_sel = long_rng ? EXP_L1 : EXP_S1;
         TO_SEL2: exp_sel = long_rng ? EXP_L2 : EXP_S2;
         TO_SEL3: exp_sel = long_rng ? EXP_L3 : EXP_S3;
      endcase
      limit = CNT_W'((19'h0_0001 << exp_sel) - 19'h0_0001);
      win_open = CNT_W'((19'h0_0001 << exp_sel) - ((19'h0_0001 << exp_sel) >> 2));
   end

   // On the bus clock the counter cannot advance in stop; with stop enable 1 it is not cleared.
   always_comb begin
      unique case (clk_sel)
         CLK_LPO: tick = src_rise[0];
         CLK_IRC: tick = src_rise[1];
         CLK_OSC: tick = src_rise[2];
         CLK_BUS: tick = ~stop_mode_i;
      endcase
   end

   // Key detection: service writes touch this state machine, the counter restart and the reset request, never the control register.
   assign key_bad = wr_srv & (avs_writedata_i[7:0] != KEY_FIRST) & (avs_writedata_i[7:0] != KEY_SECOND);
   assign service_ok = wr_srv & (key_ff == KEY_ARMED) & (avs_writedata_i[7:0] == KEY_SECOND);
   assign premature = service_ok & enabled & win_mode & (cnt_ff < win_open);

   always_comb begin
      nxt_key = key_ff;
      if (wr_srv) begin
         unique case (key_ff)
            KEY_IDLE: nxt_key = (avs_writedata_i[7:0] == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
            KEY_ARMED: nxt_key = (avs_writedata_i[7:0] == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         key_ff <= KEY_IDLE;
      end else begin
         key_ff <= nxt_key;
      end
   end

   assign timeout = enabled & ~hold_clear & tick & (cnt_ff == limit) & ~ctrl_first & ~service_ok;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (ctrl_first | service_ok | hold_clear | ~enabled) begin
         nxt_cnt = '0;
      end else if (tick) begin
         nxt_cnt = (cnt_ff == limit) ? '0 : cnt_ff + 1'b1;
      end
   end

   // The reset request is held until the system reset clears it, so it is never lost.
   always_comb begin
      nxt_rst_req = rst_req_ff | timeout | key_bad | premature;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= '0;
         rst_req_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         rst_req_ff <= nxt_rst_req;
      end
   end

   // Reference count of ticks since the last restart, and the span each setting allows, for the assertions below.
   logic [CNT_W:0] chk_ticks_ff, nxt_chk_ticks;
   logic [CNT_W:0] chk_span;

   always_comb begin
      unique case (to_sel)
         TO_OFF: chk_span = '1;
         TO_SEL1: chk_span = long_rng ? (19'h0_0001 << EXP_L1) : (19'h0_0001 << EXP_S1);
         TO_SEL2: chk_span = long_rng ? (19'h0_0001 << EXP_L2) : (19'h0_0001 << EXP_S2);
         TO_SEL3: chk_span = long_rng ? (19'h0_0001 << EXP_L3) : (19'h0_0001 << EXP_S3);
      endcase
   end

   always_comb begin
      nxt_chk_ticks = chk_ticks_ff;
      if (ctrl_first | service_ok | hold_clear | ~enabled) begin
         nxt_chk_ticks = '0;
      end else if (tick) begin
         nxt_chk_ticks = chk_ticks_ff + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chk_ticks_ff <= '0;
      end else begin
         chk_ticks_ff <= nxt_chk_ticks;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   a_bus_one_wait: assert property (req && !ack_ff |=> !avs_waitrequest_o || !req)
      else $error("access not answered after one wait cycle");
   a_srv_read_err: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == SRV_ADDR
      |-> avs_response_o == RESP_SLVERR)
      else $error("service read did not return an error");
   a_ctrl_locked: assert property (wr_ctrl && locked_ff |=> $stable(ctrl_ff))
      else $error("locked control register changed");
   a_bad_key_reset: assert property (key_bad |=> watchdog_reset_o)
      else $error("bad key did not reset");
   a_service_clears: assert property (service_ok && !premature |=> cnt_ff == 0 && !$rose(watchdog_reset_o))
      else $error("service did not restart the counter");
   a_timeout_reset: assert property (enabled && !hold_clear && tick && cnt_ff == limit && !service_ok
      && !ctrl_first |=> watchdog_reset_o)
      else $error("timeout did not reset");
   a_disabled_idle: assert property (to_sel == TO_OFF && !ctrl_first && !key_bad
      |=> cnt_ff == 0 && !$rose(watchdog_reset_o))
      else $error("disabled watchdog counted");
   a_debug_hold: assert property (debug_mode_i && !ctrl_ff[CTRL_DBG_BIT] |=> cnt_ff == 0)
      else $error("counter not held in debug");
   a_stop_hold: assert property (stop_mode_i && !ctrl_ff[CTRL_STP_BIT] |=> cnt_ff == 0)
      else $error("counter not held in stop");
   a_early_service: assert property (service_ok && win_mode && enabled && cnt_ff < win_open
      |=> watchdog_reset_o)
      else $error("early service did not reset");
   a_short_limit: assert property (enabled && !long_rng && to_sel == TO_SEL1 |-> limit == 18'h0_001F)
      else $error("short range limit wrong");
   a_span_reset: assert property (enabled && chk_ticks_ff == chk_span |-> watchdog_reset_o)
      else $error("full timeout span passed without reset");
   a_window_point: assert property (win_mode && enabled |-> {1'b0, win_open} == chk_span - (chk_span >> 2))
      else $error("window does not open at three quarters");
   a_service_keeps_ctrl: assert property (wr_srv |=> $stable(ctrl_ff) && $stable(locked_ff))
      else $error("service write changed the control register");
   a_reset_sticky: assert property (watchdog_reset_o |=> watchdog_reset_o)
      else $error("reset request was lost");
   a_first_write_lock: assert property (ctrl_first |=> locked_ff && cnt_ff == 0 && ctrl_ff == $past(avs_writedata_i[7:0]))
      else $error("first control write not taken");
   a_short_no_window: assert property (service_ok && !long_rng |=> !$rose(watchdog_reset_o))
      else $error("short range service caused a reset");
   a_bus_clock_tick: assert property (clk_sel == CLK_BUS && enabled && !hold_clear && !stop_mode_i
      && !ctrl_first && !service_ok && cnt_ff != limit |=> cnt_ff == $past(cnt_ff) + 1'b1)
      else $error("bus clock did not advance the counter");
   a_lpo_tick: assert property (clk_sel == CLK_LPO && !src_rise[0] |=> $stable(cnt_ff) || cnt_ff == '0)
      else $error("counter moved without a slow clock edge");
   a_reset_defaults: assert property ($fell(sys_rst_i) |-> ctrl_ff == CTRL_RESET && !locked_ff && !watchdog_reset_o)
      else $error("control defaults wrong after reset");

   c_service: cover property (service_ok && !premature);
   c_timeout: cover property (timeout);
   c_windowed: cover property (service_ok && win_mode && cnt_ff >= win_open);
   c_srv_read: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == SRV_ADDR);
   c_stop_frozen: cover property (stop_mode_i && ctrl_ff[CTRL_STP_BIT] && clk_sel == CLK_BUS && cnt_ff != 0);
endmodule

// >>> verif/windowed_watchdog_bench.sv
`timescale 1ns/100ps
module windowed_watchdog_bench;
   import wdog_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] avs_address_i = 16'h0000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic [1:0] avs_response_o;
   logic avs_waitrequest_o;
   logic watchdog_reset_o;
   logic lpo_clk_i = 1'b0, irc_clk_i = 1'b0, osc_clk_i = 1'b0;
   logic debug_mode_i = 1'b0, stop_mode_i = 1'b0;
   int errors = 0, cmp_count = 0, cyc = 0, ph = 0, c, i, k, p;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [7:0] tbl [8] = '{8'h0C, 8'hC4, 8'hC8, 8'hCC, 8'hC6, 8'h04, 8'h44, 8'h84};

   windowed_watchdog DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
      .avs_waitrequest_o(avs_waitrequest_o), .lpo_clk_i(lpo_clk_i), .irc_clk_i(irc_clk_i),
      .osc_clk_i(osc_clk_i), .debug_mode_i(debug_mode_i), .stop_mode_i(stop_mode_i),
      .watchdog_reset_o(watchdog_reset_o));

   always #12.5 mclk_i = ~mclk_i;

   // The three counter clock pins run at periods of 8, 6 and 10 bus cycles.
   always @(posedge mclk_i) begin
      ph <= ph + 1;
      cyc <= cyc + 1;
      lpo_clk_i <= (ph % 8) >= 4;
      irc_clk_i <= (ph % 6) >= 3;
      osc_clk_i <= (ph % 10) >= 5;
      if (cyc == 50000) begin
         errors++;
         stop_test();
      end
   end

   function automatic int ticks(input logic [7:0] v);
      logic [4:0] e;
      e = v[3:2] == TO_SEL1 ? (v[1] ? EXP_L1 : EXP_S1) : v[3:2] == TO_SEL2 ? (v[1] ? EXP_L2 : EXP_S2) :
         (v[1] ? EXP_L3 : EXP_S3);
      return 1 << e;
   endfunction

   function automatic int per(input logic [1:0] s);
      return s == CLK_LPO ? 8 : s == CLK_IRC ? 6 : s == CLK_OSC ? 10 : 1;
   endfunction

   task stop_test;
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low at a rising edge, takes the answer there, then releases.
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int w;
      w = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      do begin
         @(posedge mclk_i);
         w++;
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      rs = avs_response_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      check(w, 2, "one wait state");
      @(posedge mclk_i);
   endtask

   task do_reset;
      sys_rst_i <= 1'b1;
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   // Counts cycles until the reset request shows, giving up after n.
   task wait_rst(input int n);
      c = 0;
      while (c < n && watchdog_reset_o !== 1'b1) begin
         @(negedge mclk_i);
         c++;
      end
      @(posedge mclk_i);
   endtask

   task srv;
      bus(1'b1, SRV_ADDR, {24'h0, KEY_FIRST});
      bus(1'b1, SRV_ADDR, {24'h0, KEY_SECOND});
   endtask

   task start(input logic [7:0] v);
      do_reset();
      bus(1'b1, CTRL_ADDR, {24'h0, v});
   endtask

   initial begin
      void'($urandom(32'h74f45b07));
      do_reset();
      bus(1'b0, CTRL_ADDR, 32'h0);
      check(rd, {24'h0, CTRL_RESET}, "control reset");
      bus(1'b0, SRV_ADDR, 32'h0);
      check({30'h0, rs}, {30'h0, RESP_SLVERR}, "service read");
      check(rd, 32'h0, "service read data");
      bus(1'b0, 16'h1108, 32'h0);
      check({30'h0, rs}, {30'h0, RESP_DECERR}, "unmapped read");
      for (i = 0; i < 8; i++) begin
         if (i == 0)
            do_reset();
         else
            start(tbl[i]);
         p = per(tbl[i][7:6]);
         k = ticks(tbl[i]) * p;
         wait_rst(k + p + 4);
         check({31'h0, c >= k - p && c < k + p + 4}, 32'h1, "timeout");
      end
      start(8'hC4);
      bus(1'b1, CTRL_ADDR, 32'h0);
      for (i = 0; i < 6; i++) begin
         k = $urandom_range(20, 4);
         wait_rst(k);
         check(c, k, "early reset");
         srv();
      end
      bus(1'b0, CTRL_ADDR, 32'h0);
      check(rd, 32'hC4, "control locked");
      do k = $urandom_range(255, 0); while (k == 8'h55 || k == 8'hAA);
      bus(1'b1, SRV_ADDR, k);
      wait_rst(3);
      check({31'h0, c < 3}, 32'h1, "bad key");
      start(8'hC0);
      wait_rst(400);
      check(c, 400, "disabled");
      start(8'hC5);
      srv();
      wait_rst(20);
      check(c, 20, "short range no window");
      start(8'hC7);
      wait_rst(100);
      srv();
      wait_rst(3);
      check({31'h0, c < 3}, 32'h1, "early service");
      start(8'hC7);
      wait_rst(6300);
      srv();
      wait_rst(8000);
      check(c, 8000, "late service");
      for (i = 0; i < 4; i++) begin
         start(i == 2 ? 8'hE4 : i == 3 ? 8'hD4 : 8'hC4);
         debug_mode_i <= i == 0 || i == 2;
         stop_mode_i <= i[0];
         wait_rst(200);
         check({31'h0, c < 200}, {31'h0, i == 2}, "mode hold");
         debug_mode_i <= 1'b0;
         stop_mode_i <= 1'b0;
      end
      stop_test();
   end
endmodule
